// *** logic/output_setpoint_trigger_control.sv ***
// Setpoint, overvoltage guard and trigger controller with AXI4-Lite registers
`timescale 1ns/1ps
// Summary of operation
// R1 - Step up/down moves voltage setpoint by exactly the programmed step size
// R2 - Default step is minimum resolution; command reset restores that minimum
// R3 - Step query returns programmed step, or minimum resolution when default asked
// R4 - Pending voltage setpoint copies to output only on trigger
// R5 - Unprogrammed pending level reads back as immediate voltage setpoint
// R6 - Peak above trip level with guard enabled shorts output, sets flag
// R7 - Guard enable is settable, reads 0 or 1, forced on by reset command
// R8 - Trip status reads 1 while latched and uncleared, else 0
// R9 - Clear releases latch, restores prior setpoint, keeps trip level
// R10 - Host lowers setpoint or raises level and removes cause before clearing
// R11 - Low range caps 8.24 V and 20.60 A; reset selects low range
// R12 - High range caps 20.60 V and 10.30 A
// R13 - Range readback shows high or low range code
// R14 - Min/max readbacks give lowest and highest levels for current range; only the max readbacks (VLIMIT, ILIMIT) exist
// R15 - Trigger source volatile, returns to bus at power-up and reset
// R16 - Delay accepted 0 to 3600 s, reset to 0
// R17 - Delay applies only for bus source, ignored for immediate
// R18 - Arm with immediate source does one full trigger cycle at once
// R19 - Arm with bus source only arms; bus trigger acts after delay
// R20 - Software trigger acts only with bus source, same as group trigger
// R21 - Wait holds further commands until pending trigger action completes
// R22 - Completion sets done flag for query or event bit 0 for command
// R23 - Host enters remote mode before serial software triggers
// R24 - Step beyond rated min or max rejected with error -222
// R25 - Delay timed by one-second tick; triggers refused while delay runs
// R26 - Setpoint updates take one cycle; trip latch has priority
module output_setpoint_trigger_control #(
  parameter int          TICK_CYCLES = setpoint_pkg::TICK_CYCLES,
  parameter logic [31:0] VSTEP_MIN   = setpoint_pkg::VSTEP_MIN_A
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        group_trigger,
  input  wire logic [31:0] peak_voltage,
  output logic [31:0]      voltage_setpoint,
  output logic [31:0]      current_setpoint,
  output logic             output_short
);
  setpoint_pkg::ctrl_s ctrl_q;
  logic [31:0] vset_q, vstep_q, vpend_q, iset_q, ipend_q, ovlevel_q, vsaved_q;
  logic [31:0] peak_s1_q, peak_q;
  logic        get_s1_q, get_s2_q, get_s3_q;
  logic        pend_prog_q, trip_q, armed_q, dly_q, opc_pend_q, opc_q, done_q;
  logic        err_q;
  logic [15:0] errcode_q;
  logic [11:0] delay_q, dly_cnt_q;
  logic [26:0] tick_cnt_q;
  logic        tick;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic        aw_have_q, w_have_q;
  logic        wr_go, bus_trg, fire, busy;
  logic [31:0] vmax, imax, wmask, wr_val;

  // Write channel: capture address and data in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  // Any command register write stalls write completion while a delayed action runs
  assign busy   = dly_q || armed_q && ctrl_q.src_imm;
  assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid &&
                  !(busy && aw_q == setpoint_pkg::REG_CMD); // [R21]
  assign s_axi_bresp = 2'b00;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_q      <= 8'h00;
      w_q       <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q      <= s_axi_wdata & wmask;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
    end
  endgenerate

  assign wr_val = w_q;
  assign vmax = ctrl_q.range_high ? setpoint_pkg::VMAX_HIGH : setpoint_pkg::VMAX_LOW; // [R11] [R12]
  assign imax = ctrl_q.range_high ? setpoint_pkg::IMAX_HIGH : setpoint_pkg::IMAX_LOW; // [R11] [R12]

  function automatic logic [31:0] clip(input logic [31:0] v, input logic [31:0] lim);
    clip = (v > lim) ? lim : v;
  endfunction

  logic wr_cmd, cmd_rst;
  assign wr_cmd  = wr_go && aw_q == setpoint_pkg::REG_CMD;
  assign cmd_rst = wr_cmd && wr_val[setpoint_pkg::CMD_RST];

  // Limits that hold after this edge, so a range change clips setpoints at once
  logic        rng_wr, nx_high;
  logic [31:0] vmax_nx, imax_nx;
  assign rng_wr  = wr_go && aw_q == setpoint_pkg::REG_CTRL;
  assign nx_high = rng_wr ? wr_val[setpoint_pkg::CTRL_RANGE] : ctrl_q.range_high;
  assign vmax_nx = nx_high ? setpoint_pkg::VMAX_HIGH : setpoint_pkg::VMAX_LOW; // [R11] [R12]
  assign imax_nx = nx_high ? setpoint_pkg::IMAX_HIGH : setpoint_pkg::IMAX_LOW; // [R11] [R12]

  // Group trigger pin synchroniser and edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      get_s1_q  <= 1'b0;
      get_s2_q  <= 1'b0;
      get_s3_q  <= 1'b0;
      peak_s1_q <= 32'h0000_0000;
      peak_q    <= 32'h0000_0000;
    end else begin
      get_s1_q  <= group_trigger;
      get_s2_q  <= get_s1_q;
      get_s3_q  <= get_s2_q;
      peak_s1_q <= peak_voltage;
      peak_q    <= peak_s1_q;
    end
  end

  // Bus trigger: software command or group trigger, bus source only
  assign bus_trg = !ctrl_q.src_imm && armed_q && !dly_q &&
                   ((wr_cmd && wr_val[setpoint_pkg::CMD_TRG]) ||
                    (get_s2_q && !get_s3_q)); // [R20] [R25]
  // Trigger action fires on immediate arm, zero delay, or delay expiry
  logic arm_imm;
  assign arm_imm = wr_cmd && wr_val[setpoint_pkg::CMD_ARM] && ctrl_q.src_imm; // [R18] [R17]
  assign fire = arm_imm || (bus_trg && delay_q == 12'd0) ||
                (dly_q && tick && dly_cnt_q == 12'd1); // [R19]

  // One-second tick divider
  always_ff @(posedge aclk) begin
    if (!aresetn || !dly_q) begin
      tick_cnt_q <= 27'd0;
    end else if (tick) begin
      tick_cnt_q <= 27'd0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 27'd1;
    end
  end
  assign tick = dly_q && tick_cnt_q == 27'(TICK_CYCLES - 1); // [R25]

  // Arm and delay state
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_rst) begin
      armed_q   <= 1'b0;
      dly_q     <= 1'b0;
      dly_cnt_q <= 12'd0;
    end else begin
      if (wr_cmd && wr_val[setpoint_pkg::CMD_ARM] && !ctrl_q.src_imm) begin
        armed_q <= 1'b1; // [R19]
      end else if (bus_trg) begin
        armed_q <= 1'b0;
      end
      if (bus_trg && delay_q != 12'd0) begin
        dly_q     <= 1'b1; // [R25]
        dly_cnt_q <= delay_q;
      end else if (dly_q && tick) begin
        dly_cnt_q <= dly_cnt_q - 12'd1;
        if (dly_cnt_q == 12'd1) begin
          dly_q <= 1'b0;
        end
      end
    end
  end

  // Configuration: control, step, delay, trip level
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_rst) begin
      ctrl_q.guard_en   <= 1'b1;        // [R7]
      ctrl_q.range_high <= 1'b0;        // [R11]
      ctrl_q.src_imm    <= 1'b0;        // [R15]
      ctrl_q.step_def_q <= 1'b0;
      vstep_q           <= VSTEP_MIN;   // [R2]
      delay_q           <= 12'd0;       // [R16]
      ovlevel_q         <= setpoint_pkg::OVLEVEL_RST;
    end else if (wr_go) begin
      unique case (aw_q)
        setpoint_pkg::REG_CTRL: begin
          ctrl_q.guard_en   <= wr_val[setpoint_pkg::CTRL_GUARD]; // [R7]
          ctrl_q.range_high <= wr_val[setpoint_pkg::CTRL_RANGE];
          ctrl_q.src_imm    <= wr_val[setpoint_pkg::CTRL_SRC];
          ctrl_q.step_def_q <= wr_val[setpoint_pkg::CTRL_STEPQ];
        end
        setpoint_pkg::REG_VSTEP:   vstep_q   <= (wr_val == 32'd0) ? VSTEP_MIN : wr_val; // [R2]
        setpoint_pkg::REG_DELAY:   delay_q   <= (wr_val > 32'(setpoint_pkg::DELAY_MAX)) ?
                                                setpoint_pkg::DELAY_MAX : wr_val[11:0]; // [R16]
        setpoint_pkg::REG_OVLEVEL: ovlevel_q <= wr_val;
        default: ;
      endcase
    end
  end

  // Step bounds check
  logic up_cmd, dn_cmd, up_bad, dn_bad;
  assign up_cmd = wr_cmd && wr_val[setpoint_pkg::CMD_UP];
  assign dn_cmd = wr_cmd && wr_val[setpoint_pkg::CMD_DOWN];
  assign up_bad = {1'b0, vset_q} + {1'b0, vstep_q} > {1'b0, vmax}; // [R24]
  assign dn_bad = vstep_q > vset_q;                                // [R24]

  // Setpoints; trip latch wins over every setpoint write
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_rst) begin
      vset_q      <= setpoint_pkg::VMIN;
      vpend_q     <= setpoint_pkg::VMIN;
      iset_q      <= setpoint_pkg::ISET_RST;
      ipend_q     <= setpoint_pkg::ISET_RST;
      pend_prog_q <= 1'b0;
    end else if (!trip_q) begin // [R26]
      if (rng_wr) begin
        vset_q  <= clip(vset_q, vmax_nx);  // [R11] [R12]
        vpend_q <= clip(vpend_q, vmax_nx);
        iset_q  <= clip(iset_q, imax_nx);
        ipend_q <= clip(ipend_q, imax_nx);
      end
      if (wr_go && aw_q == setpoint_pkg::REG_VSET)  vset_q  <= clip(wr_val, vmax); // [R14]
      if (wr_go && aw_q == setpoint_pkg::REG_ISET)  iset_q  <= clip(wr_val, imax);
      if (wr_go && aw_q == setpoint_pkg::REG_IPEND) ipend_q <= clip(wr_val, imax);
      if (wr_go && aw_q == setpoint_pkg::REG_VPEND) begin
        vpend_q     <= clip(wr_val, vmax); // [R4]
        pend_prog_q <= 1'b1;
      end
      if (up_cmd && !up_bad) vset_q <= vset_q + vstep_q; // [R1]
      if (dn_cmd && !dn_bad) vset_q <= vset_q - vstep_q; // [R1]
      if (fire) begin
        vset_q <= clip(pend_prog_q ? vpend_q : vset_q, vmax_nx); // [R4] [R18]
        iset_q <= clip(ipend_q, imax_nx);
      end
    end else if (rng_wr) begin
      vset_q  <= clip(vset_q, vmax_nx);  // [R11] [R12]
      vpend_q <= clip(vpend_q, vmax_nx);
      iset_q  <= clip(iset_q, imax_nx);
      ipend_q <= clip(ipend_q, imax_nx);
    end
  end

  // Overvoltage trip latch, saved setpoint restored on clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_q   <= 1'b0;
      vsaved_q <= 32'h0000_0000;
    end else if (!trip_q && ctrl_q.guard_en && peak_q > ovlevel_q) begin
      trip_q   <= 1'b1; // [R6]
      vsaved_q <= vset_q;
    end else if (trip_q && wr_cmd && wr_val[setpoint_pkg::CMD_CLEAR]) begin
      trip_q <= 1'b0;   // [R9]
    end else if (trip_q && rng_wr) begin
      vsaved_q <= clip(vsaved_q, vmax_nx);
    end
  end
  assign output_short     = trip_q;                          // [R6]
  assign voltage_setpoint = trip_q ? 32'h0000_0000 : vset_q; // [R9]
  assign current_setpoint = iset_q;

  // Completion and error flags; hardware set wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opc_pend_q <= 1'b0;
      opc_q      <= 1'b0;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
      errcode_q  <= 16'h0000;
    end else begin
      if (wr_cmd && wr_val[setpoint_pkg::CMD_OPC]) opc_pend_q <= 1'b1;
      if (wr_cmd && wr_val[setpoint_pkg::CMD_CLS]) begin
        opc_q  <= 1'b0;
        done_q <= 1'b0;
        err_q  <= 1'b0;
      end
      if (!busy && !(bus_trg && delay_q != 12'd0)) begin
        done_q <= 1'b1; // [R22]
        if (opc_pend_q) begin
          opc_q      <= 1'b1; // [R22]
          opc_pend_q <= 1'b0;
        end
      end else begin
        done_q <= 1'b0;
      end
      if ((up_cmd && up_bad) || (dn_cmd && dn_bad)) begin
        err_q     <= 1'b1; // [R24]
        errcode_q <= setpoint_pkg::ERR_RANGE;
      end
    end
  end

  // Read channel
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      setpoint_pkg::REG_VSET:    rd_val = vset_q;
      setpoint_pkg::REG_VSTEP:   rd_val = ctrl_q.step_def_q ? VSTEP_MIN : vstep_q; // [R3]
      setpoint_pkg::REG_VPEND:   rd_val = pend_prog_q ? vpend_q : vset_q;          // [R5]
      setpoint_pkg::REG_ISET:    rd_val = iset_q;
      setpoint_pkg::REG_IPEND:   rd_val = ipend_q;
      setpoint_pkg::REG_OVLEVEL: rd_val = ovlevel_q;
      setpoint_pkg::REG_CTRL:    rd_val = {28'h0000000, ctrl_q.step_def_q, ctrl_q.src_imm,
                                           ctrl_q.range_high, ctrl_q.guard_en}; // [R13]
      setpoint_pkg::REG_STATUS:  rd_val = {23'h000000, err_q, pend_prog_q, busy, done_q,
                                           opc_q, dly_q, armed_q, trip_q, trip_q}; // [R8]
      setpoint_pkg::REG_DELAY:   rd_val = {20'h00000, delay_q};
      setpoint_pkg::REG_VPEAK:   rd_val = peak_q;
      setpoint_pkg::REG_VLIMIT:  rd_val = vmax; // [R14]
      setpoint_pkg::REG_ILIMIT:  rd_val = imax;
      setpoint_pkg::REG_ERRCODE: rd_val = {16'h0000, errcode_q};
      default:                   rd_val = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  property p_step_up;
    @(posedge aclk) disable iff (!aresetn)
      (up_cmd && !up_bad && !dn_cmd && !fire && !trip_q && !cmd_rst) |=>
        vset_q == $past(vset_q) + $past(vstep_q);
  endproperty
  a_step_up: assert property (p_step_up) else $error("step up wrong"); // [R1]

  property p_step_reject;
    @(posedge aclk) disable iff (!aresetn)
      (up_cmd && up_bad && !fire && !cmd_rst) |=> err_q && errcode_q == 16'hff22;
  endproperty
  a_step_reject: assert property (p_step_reject) else $error("range error missing"); // [R24]

  property p_trip;
    @(posedge aclk) disable iff (!aresetn)
      (!trip_q && ctrl_q.guard_en && peak_q > ovlevel_q) |=> output_short && voltage_setpoint == 0;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not latched"); // [R6]

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
      (trip_q && wr_cmd && wr_val[2]) |=>
        !trip_q && $stable(ovlevel_q) && voltage_setpoint == $past(vsaved_q);
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // [R9]

  property p_vlimit;
    @(posedge aclk) disable iff (!aresetn)
      vset_q <= (ctrl_q.range_high ? 32'd20600000 : 32'd8240000);
  endproperty
  a_vlimit: assert property (p_vlimit) else $error("range cap exceeded"); // [R11]

  property p_imm_fire;
    @(posedge aclk) disable iff (!aresetn)
      (arm_imm && !trip_q && !cmd_rst && pend_prog_q) |=> vset_q == $past(vpend_q);
  endproperty
  a_imm_fire: assert property (p_imm_fire) else $error("immediate trigger missed"); // [R18]

  property p_src_gate;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_q.src_imm |-> !bus_trg;
  endproperty
  a_src_gate: assert property (p_src_gate) else $error("bus trigger in immediate mode"); // [R20]

  property p_delay_max;
    @(posedge aclk) disable iff (!aresetn)
      delay_q <= 12'd3600 && dly_cnt_q <= 12'd3600;
  endproperty
  a_delay_max: assert property (p_delay_max) else $error("delay above limit"); // [R16]
endmodule // output_setpoint_trigger_control

// *** logic/setpoint_pkg.sv ***
// Package: register map, reset values, field layout and timing constants
package setpoint_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_VSET    = 8'h00; // Immediate voltage setpoint (uV)
  localparam logic [7:0] REG_VSTEP   = 8'h04; // voltage_step_size (uV), write 0 = default
  localparam logic [7:0] REG_VPEND   = 8'h08; // pending_voltage_setpoint (uV)
  localparam logic [7:0] REG_ISET    = 8'h0c; // Immediate current setpoint (uA)
  localparam logic [7:0] REG_IPEND   = 8'h10; // Pending current setpoint (uA)
  localparam logic [7:0] REG_OVLEVEL = 8'h14; // overvoltage_trip_level (uV)
  localparam logic [7:0] REG_CTRL    = 8'h18; // Control bits
  localparam logic [7:0] REG_CMD     = 8'h1c; // Command strobes (write only)
  localparam logic [7:0] REG_STATUS  = 8'h20; // Status (read only)
  localparam logic [7:0] REG_DELAY   = 8'h24; // trigger_delay_setting (s)
  localparam logic [7:0] REG_VPEAK   = 8'h28; // Measured peak voltage (uV, read only)
  localparam logic [7:0] REG_VLIMIT  = 8'h2c; // Range max voltage (uV, read only)
  localparam logic [7:0] REG_ILIMIT  = 8'h30; // Range max current (uA, read only)
  localparam logic [7:0] REG_ERRCODE = 8'h34; // Last execution error code (read only)

  // CTRL bit positions
  localparam int CTRL_GUARD = 0; // overvoltage_guard_enable
  localparam int CTRL_RANGE = 1; // output_range_select: 1 = high
  localparam int CTRL_SRC   = 2; // trigger_source_select: 1 = immediate
  localparam int CTRL_STEPQ = 3; // Step readback shows default resolution
  // CMD bit positions
  localparam int CMD_UP    = 0;
  localparam int CMD_DOWN  = 1;
  localparam int CMD_CLEAR = 2; // overvoltage_latch_clear
  localparam int CMD_ARM   = 3;
  localparam int CMD_TRG   = 4;
  localparam int CMD_WAIT  = 5;
  localparam int CMD_OPC   = 6;
  localparam int CMD_RST   = 7;
  localparam int CMD_CLS   = 8;
  // STATUS bit positions
  localparam int ST_TRIP   = 0;
  localparam int ST_OVFLAG = 1; // overvoltage_flag in questionable status
  localparam int ST_ARMED  = 2;
  localparam int ST_DELAY  = 3;
  localparam int ST_OPC    = 4; // Standard event bit 0
  localparam int ST_DONE   = 5; // Completion query answer
  localparam int ST_BUSY   = 6;
  localparam int ST_PENDV  = 7;
  localparam int ST_ERR    = 8;

  // Setpoint values in microvolts / microamps
  localparam logic [31:0] VSTEP_MIN_A = 32'd360;      // 0.36 mV
  localparam logic [31:0] VSTEP_MIN_B = 32'd950;      // 0.95 mV
  localparam logic [31:0] VMAX_LOW    = 32'd8240000;  // 8.24 V
  localparam logic [31:0] VMAX_HIGH   = 32'd20600000; // 20.60 V
  localparam logic [31:0] IMAX_LOW    = 32'd20600000; // 20.60 A
  localparam logic [31:0] IMAX_HIGH   = 32'd10300000; // 10.30 A
  localparam logic [31:0] VMIN        = 32'd0;
  localparam logic [31:0] OVLEVEL_RST = 32'd22000000;
  localparam logic [31:0] ISET_RST    = 32'd20000000;
  localparam logic [11:0] DELAY_MAX   = 12'd3600;
  localparam logic [15:0] ERR_RANGE   = 16'hff22;     // -222, data out of range

  // One second tick derived from 125 MHz
  localparam int CLK_HZ       = 125000000;
  localparam int TICK_SECONDS = 1;
  localparam int TICK_CYCLES  = CLK_HZ * TICK_SECONDS;

  typedef struct packed {
    logic guard_en;
    logic range_high;
    logic src_imm;
    logic step_def_q;
  } ctrl_s;
endpackage

// *** test/host_side_model.sv ***
// Far-side model: group trigger message and measured peak voltage source
`timescale 1ns/1ps
module host_side_model (
  input  wire logic   aclk,
  output logic        group_trigger,
  output logic [31:0] peak_voltage
);
  initial begin
    group_trigger = 1'b0;
    peak_voltage  = 32'h0;
  end

  // Remote mode is taken as entered before any bus trigger is sent
  task automatic fire_trigger();
    @(posedge aclk);
    group_trigger <= 1'b1;
    repeat (3) @(posedge aclk);
    group_trigger <= 1'b0;
  endtask

  // The cause of a trip is removed by lowering this before a clear
  task automatic set_peak(input logic [31:0] v);
    @(posedge aclk);
    peak_voltage <= v;
  endtask
endmodule // host_side_model

// *** test/testbench.sv ***
// Self-checking bench for the setpoint and trigger controller
`timescale 1ns/1ps
module testbench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, group_trigger, output_short;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, peak_voltage, voltage_setpoint, current_setpoint;
  int          err_count, cmp_count, cycles;

  output_setpoint_trigger_control #(.TICK_CYCLES(10), .VSTEP_MIN(setpoint_pkg::VSTEP_MIN_A))
  u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .group_trigger, .peak_voltage, .voltage_setpoint, .current_setpoint,
    .output_short);
  host_side_model u_host (.aclk, .group_trigger, .peak_voltage);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("Error %0t: run timed out", $time);
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  // Read a register and compare the masked word
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
  endtask

  task automatic cmd(input int b);
    wr(setpoint_pkg::REG_CMD, 32'h1 << b);
  endtask

  task automatic t_reset();
    rc(setpoint_pkg::REG_VSTEP, 32'd360);
    rc(setpoint_pkg::REG_DELAY, 32'h0);
    wr(setpoint_pkg::REG_VSET, 32'd2500);
    rc(setpoint_pkg::REG_VPEND, 32'd2500);
    wr(setpoint_pkg::REG_CTRL, 32'h6);
    rc(setpoint_pkg::REG_CTRL, 32'h6, 32'h7);
    wr(setpoint_pkg::REG_VSTEP, 32'd1000);
    cmd(setpoint_pkg::CMD_RST);
    rc(setpoint_pkg::REG_CTRL, 32'h1, 32'h7);
    rc(setpoint_pkg::REG_VSTEP, 32'd360);
  endtask

  task automatic t_step();
    wr(setpoint_pkg::REG_VSTEP, 32'd1000);
    wr(setpoint_pkg::REG_VSET, 32'd5000);
    cmd(setpoint_pkg::CMD_UP);
    chk(voltage_setpoint, 32'd6000);
    cmd(setpoint_pkg::CMD_DOWN);
    cmd(setpoint_pkg::CMD_DOWN);
    chk(voltage_setpoint, 32'd4000);
    rc(setpoint_pkg::REG_VSTEP, 32'd1000);
    wr(setpoint_pkg::REG_CTRL, 32'h9);
    rc(setpoint_pkg::REG_VSTEP, 32'd360);
    wr(setpoint_pkg::REG_CTRL, 32'h1);
    wr(setpoint_pkg::REG_VSET, 32'h0);
    cmd(setpoint_pkg::CMD_DOWN);
    chk(voltage_setpoint, 32'h0);
    rc(setpoint_pkg::REG_ERRCODE, 32'h0000ff22, 32'h0000ffff);
  endtask

  task automatic t_range();
    rc(setpoint_pkg::REG_VLIMIT, 32'd8240000);
    rc(setpoint_pkg::REG_ILIMIT, 32'd20600000);
    wr(setpoint_pkg::REG_CTRL, 32'h3);
    rc(setpoint_pkg::REG_CTRL, 32'h2, 32'h2);
    rc(setpoint_pkg::REG_VLIMIT, 32'd20600000);
    rc(setpoint_pkg::REG_ILIMIT, 32'd10300000);
    wr(setpoint_pkg::REG_VSET, 32'd30000000);
    rc(setpoint_pkg::REG_VSET, 32'd20600000);
    wr(setpoint_pkg::REG_CTRL, 32'h1);
    rc(setpoint_pkg::REG_VSET, 32'd8240000);
    rc(8'h3c, 32'h0);
  endtask

  task automatic t_trigger();
    wr(setpoint_pkg::REG_VPEND, 32'd3000);
    wr(setpoint_pkg::REG_VSET, 32'd7000);
    rc(setpoint_pkg::REG_VPEND, 32'd3000);
    cmd(setpoint_pkg::CMD_ARM);
    chk(voltage_setpoint, 32'd7000);
    cmd(setpoint_pkg::CMD_TRG);
    chk(voltage_setpoint, 32'd3000);
    chk(current_setpoint, 32'd10300000);
    wr(setpoint_pkg::REG_VPEND, 32'd4000);
    wr(setpoint_pkg::REG_DELAY, 32'd3);
    wr(setpoint_pkg::REG_CTRL, 32'h5);
    cmd(setpoint_pkg::CMD_TRG);
    chk(voltage_setpoint, 32'd3000);
    cmd(setpoint_pkg::CMD_ARM);
    chk(voltage_setpoint, 32'd4000);
    wr(setpoint_pkg::REG_CTRL, 32'h1);
  endtask

  task automatic t_delay();
    wr(setpoint_pkg::REG_DELAY, 32'd5000);
    rc(setpoint_pkg::REG_DELAY, 32'd3600);
    wr(setpoint_pkg::REG_DELAY, 32'd2);
    wr(setpoint_pkg::REG_VPEND, 32'd6000);
    cmd(setpoint_pkg::CMD_ARM);
    u_host.fire_trigger();
    repeat (6) @(posedge aclk);
    chk(voltage_setpoint, 32'd4000);
    rc(setpoint_pkg::REG_STATUS, 32'h8, 32'h8);
    cmd(setpoint_pkg::CMD_WAIT);
    chk(voltage_setpoint, 32'd6000);
    rc(setpoint_pkg::REG_STATUS, 32'h20, 32'h20);
    cmd(setpoint_pkg::CMD_OPC);
    rc(setpoint_pkg::REG_STATUS, 32'h10, 32'h10);
  endtask

  task automatic t_guard();
    wr(setpoint_pkg::REG_OVLEVEL, 32'd1000000);
    u_host.set_peak(32'd2000000);
    repeat (8) @(posedge aclk);
    chk(output_short, 32'h1);
    chk(voltage_setpoint, 32'h0);
    rc(setpoint_pkg::REG_STATUS, 32'h3, 32'h3);
    u_host.set_peak(32'h0);
    repeat (4) @(posedge aclk);
    cmd(setpoint_pkg::CMD_CLEAR);
    chk(output_short, 32'h0);
    chk(voltage_setpoint, 32'd6000);
    rc(setpoint_pkg::REG_OVLEVEL, 32'd1000000);
    rc(setpoint_pkg::REG_STATUS, 32'h0, 32'h1);
    wr(setpoint_pkg::REG_CTRL, 32'h0);
    u_host.set_peak(32'd2000000);
    repeat (8) @(posedge aclk);
    chk(output_short, 32'h0);
    u_host.set_peak(32'h0);
  endtask

  initial begin
    {err_count, cmp_count, cycles} = '0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_step();
    t_range();
    t_trigger();
    t_delay();
    t_guard();
    test_done();
  end
endmodule // testbench
